// ### core/pll_clk_pkg.sv
// Constants, field positions and state types of the PLL clock selector
package pll_clk_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] BAND_ADDR = 8'h04;
    localparam logic [7:0] PROG_ADDR = 8'h08;
    // Control register fields
    localparam int IE_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int BCS_BIT = 4;
    localparam logic [3:0] CTRL_LOW_READ = 4'hf;
    // Bandwidth register fields
    localparam int AUTO_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int ACQ_BIT = 5;
    // Programming register fields
    localparam int MUL_LSB = 4;
    localparam int VRS_LSB = 0;
    // Reset values
    localparam logic [7:0] PROG_RESET = 8'h66;
    localparam logic PLL_ON_RESET = 1'b1;
    // Edges of each source counted across a source change
    localparam logic [1:0] SWITCH_EDGES = 2'h3;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_FILL_NEW} sw_state_t;
endpackage

// ### core/sync_level_if.sv
// Synchronised level with its change events
`timescale 1ns/1ps
`default_nettype none
interface sync_level_if;
    logic level;
    logic rise;
    logic toggle;
    modport source (output level, output rise, output toggle);
    modport sink (input level, input rise, input toggle);
endinterface
`default_nettype wire

// ### core/input_sync.sv
// Three-stage input synchroniser with agreed level and edge events
`timescale 1ns/1ps
`default_nettype none
module input_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    sync_level_if.source out
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic agreed;

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            agreed <= 1'b0;
        end else if (stage2 == stage3) begin
            agreed <= stage2;
        end
    end

    assign out.level = agreed;
    assign out.rise = (stage2 == stage3) && stage2 && !agreed;
    assign out.toggle = (stage2 == stage3) && (stage2 != agreed);
endmodule
`default_nettype wire

// ### core/pll_clock_selector.sv
// PLL control registers and glitch-free base clock selector
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_selector
    import pll_clk_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic pll_lock_in,
    input wire logic pll_track_in,
    input wire logic oscillator_enable_in,
    input wire logic stop_mode_in,
    output logic base_clock_out,
    output logic lock_change_irq,
    output logic osc_run,
    output logic pll_run,
    output logic [3:0] feedback_divide_factor,
    output logic [3:0] vco_range_select,
    output logic auto_bandwidth,
    output logic tracking_select
);
    sync_level_if xtal_s();
    sync_level_if vco_s();
    sync_level_if lock_s();
    sync_level_if track_s();

    logic [7:0] aw_addr;
    logic aw_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic w_held;
    logic wr_go;
    logic [7:0] prog;
    logic pll_power_on;
    logic base_clock_select;
    logic lock_irq_enable;
    logic lock_change_flag;
    logic auto_mode;
    logic tracking_manual;
    logic range_zero;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [7:0] rd_byte;
    logic rd_hit;
    sw_state_t sw_state;
    logic active_src;
    logic [1:0] edge_count;
    logic old_rise;
    logic new_rise;

    input_sync u_xtal (.aclk(aclk), .aresetn(aresetn), .async_in(crystal_clock), .out(xtal_s));
    input_sync u_vco (.aclk(aclk), .aresetn(aresetn), .async_in(vco_clock), .out(vco_s));
    input_sync u_lock (.aclk(aclk), .aresetn(aresetn), .async_in(pll_lock_in), .out(lock_s));
    input_sync u_track (.aclk(aclk), .aresetn(aresetn), .async_in(pll_track_in), .out(track_s));

    assign range_zero = (prog[VRS_LSB +: 4] == 4'h0);
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_ctrl = wr_go && w_lane0 && (aw_addr == CTRL_ADDR);
    assign rd_ctrl = s_axi_arvalid && s_axi_arready && (s_axi_araddr == CTRL_ADDR);

    // Write channel: address and data are caught in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == CTRL_ADDR || aw_addr == BAND_ADDR
                    || aw_addr == PROG_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read view; hidden bits follow the mode, unimplemented bits read fixed values
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            CTRL_ADDR: begin
                rd_byte = {lock_irq_enable && auto_mode, lock_change_flag && auto_mode,
                    pll_power_on, base_clock_select, CTRL_LOW_READ};
            end
            BAND_ADDR: begin
                rd_byte = {auto_mode, lock_s.level && auto_mode,
                    auto_mode ? track_s.level : tracking_manual, 5'h00};
            end
            PROG_ADDR: begin
                rd_byte = prog;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read at a time, answered the cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Programming register; software packs N above L
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog <= PROG_RESET;
        end else if (wr_go && w_lane0 && aw_addr == PROG_ADDR && !pll_power_on) begin
            prog <= w_data;
        end
    end

    // PLL on/off and base clock select interlock, both judged on old state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_power_on <= PLL_ON_RESET;
            base_clock_select <= 1'b0;
        end else begin
            if (wr_ctrl && !base_clock_select) begin
                pll_power_on <= w_data[ON_BIT];
            end
            // forced zero in stop mode or range zero
            if (stop_mode_in || range_zero) begin
                base_clock_select <= 1'b0;
            // uses old PLL state, so two writes
            // Selecting in the same write that switches off is refused too
            end else if (wr_ctrl && pll_power_on && (w_data[ON_BIT] || !w_data[BCS_BIT])) begin
                base_clock_select <= w_data[BCS_BIT];
            end
        end
    end

    // Bandwidth mode and the manual tracking value kept across auto mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_mode <= 1'b0;
            tracking_manual <= 1'b0;
        end else if (wr_go && w_lane0 && aw_addr == BAND_ADDR) begin
            auto_mode <= w_data[AUTO_BIT];
            if (!auto_mode) begin
                tracking_manual <= w_data[ACQ_BIT];
            end
        end
    end

    // Interrupt enable and lock change flag; a set beats a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_irq_enable <= 1'b0;
            lock_change_flag <= 1'b0;
        end else begin
            if (!auto_mode) begin
                lock_irq_enable <= 1'b0;
            end else if (wr_ctrl) begin
                lock_irq_enable <= w_data[IE_BIT];
            end
            // lock toggle sets, control read clears
            if (lock_s.toggle) begin
                lock_change_flag <= 1'b1;
            end else if (rd_ctrl) begin
                lock_change_flag <= 1'b0;
            end
        end
    end

    // Outputs towards the analog loop and the integration module
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_run <= 1'b0;
            pll_run <= 1'b0;
            lock_change_irq <= 1'b0;
            feedback_divide_factor <= 4'h1;
            vco_range_select <= 4'h0;
            auto_bandwidth <= 1'b0;
            tracking_select <= 1'b0;
        end else begin
            osc_run <= oscillator_enable_in;
            pll_run <= oscillator_enable_in && pll_power_on && !range_zero;
            lock_change_irq <= lock_change_flag && lock_irq_enable && auto_mode;
            feedback_divide_factor <= (prog[MUL_LSB +: 4] == 4'h0) ? 4'h1 : prog[MUL_LSB +: 4];
            vco_range_select <= prog[VRS_LSB +: 4];
            auto_bandwidth <= auto_mode;
            tracking_select <= tracking_manual;
        end
    end

    assign old_rise = active_src ? vco_s.rise : xtal_s.rise;
    assign new_rise = active_src ? xtal_s.rise : vco_s.rise;

    // Source switch: drain old edges, then fill new, output frozen meanwhile.
    // A stopped source stalls the switch; the interlocks keep VCO alive while base_clock_select is set, not while its old edges drain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_state <= SW_RUN;
            active_src <= 1'b0;
            edge_count <= 2'h0;
        end else begin
            unique case (sw_state)
                SW_RUN: begin
                    if (active_src != base_clock_select) begin
                        sw_state <= SW_DRAIN_OLD;
                        edge_count <= 2'h0;
                    end
                end
                SW_DRAIN_OLD: begin
                    if (old_rise) begin
                        if (edge_count == SWITCH_EDGES - 2'h1) begin
                            sw_state <= SW_FILL_NEW;
                            edge_count <= 2'h0;
                        end else begin
                            edge_count <= edge_count + 2'h1;
                        end
                    end
                end
                SW_FILL_NEW: begin
                    if (new_rise) begin
                        if (edge_count == SWITCH_EDGES - 2'h1) begin
                            sw_state <= SW_RUN;
                            active_src <= !active_src;
                            edge_count <= 2'h0;
                        end else begin
                            edge_count <= edge_count + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Base clock toggles once per source rising edge: half rate, even duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_clock_out <= 1'b0;
        end else if (sw_state == SW_RUN && active_src == base_clock_select && old_rise) begin
            base_clock_out <= !base_clock_out;
        end
    end

    a_prog_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        pll_power_on |=> $stable(prog))
        else $error("programming register changed while PLL on");
    a_mul_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        prog[7:4] == 4'h0 |=> feedback_divide_factor == 4'h1)
        else $error("zero multiplier not treated as one");
    a_range_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        range_zero |=> !base_clock_select && !pll_run)
        else $error("range zero did not force crystal");
    a_select_needs_on: assert property (@(posedge aclk) disable iff (!aresetn)
        base_clock_select |-> pll_power_on)
        else $error("VCO selected with PLL off");
    a_on_held: assert property (@(posedge aclk) disable iff (!aresetn)
        base_clock_select |=> pll_power_on)
        else $error("PLL switched off while selected");
    a_two_writes: assert property (@(posedge aclk) disable iff (!aresetn)
        !pll_power_on |=> !base_clock_select)
        else $error("VCO selected in same write as PLL on");
    a_manual_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        !auto_mode |=> !lock_irq_enable)
        else $error("interrupt enable set in manual mode");
    a_manual_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !auto_mode && s_axi_araddr == BAND_ADDR
        |=> !s_axi_rdata[LOCK_BIT])
        else $error("lock read nonzero in manual mode");
    a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_s.toggle |=> lock_change_flag
        ##1 (lock_change_irq == ($past(lock_irq_enable) && $past(auto_mode))))
        else $error("lock toggle did not set flag");
    a_irq_source: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_change_irq |-> $past(lock_change_flag) && $past(auto_mode))
        else $error("interrupt without lock change");
    a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_mode_in |=> !base_clock_select)
        else $error("stop did not clear select");
    a_osc_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !oscillator_enable_in |=> !osc_run && !pll_run)
        else $error("oscillator or PLL ran without enable");
    a_hold_static: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_state != SW_RUN |=> $stable(base_clock_out))
        else $error("base clock moved during source change");
    a_half_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_state == SW_RUN && active_src == base_clock_select && old_rise
        |=> base_clock_out != $past(base_clock_out))
        else $error("base clock missed a source edge");
endmodule
`default_nettype wire

// ### sim/sim_side_model.sv
// Far-side model: source clocks, oscillator enable and stop requests
`timescale 1ns/1ps
`default_nettype none
module sim_side_model (
    input wire logic aclk,
    input wire logic osc_run,
    input wire logic pll_run,
    input wire logic en_req,
    input wire logic stop_req,
    output logic crystal_clock,
    output logic vco_clock,
    output logic oscillator_enable_in,
    output logic stop_mode_in
);
    initial begin
        crystal_clock = 1'b0;
        forever #40 crystal_clock = osc_run ? ~crystal_clock : 1'b0;
    end
    // VCO gated by run; kept slower than aclk/4 so every rise is seen
    initial begin
        vco_clock = 1'b0;
        forever #24 vco_clock = pll_run ? ~vco_clock : 1'b0;
    end
    // Levels valid from time zero
    initial begin
        oscillator_enable_in = 1'b1;
        stop_mode_in = 1'b0;
    end
    // Requests launched just after the rising edge
    always @(posedge aclk) begin
        oscillator_enable_in <= en_req;
        stop_mode_in <= stop_req;
    end
endmodule
`default_nettype wire

// ### sim/pll_base_clock_selector_tb_top.sv
// Self-checking bench for the PLL clock selector over its register bus
`timescale 1ns/1ps
`default_nettype none
module pll_base_clock_selector_tb_top
    import pll_clk_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pll_lock_in, pll_track_in, en_req, stop_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, feedback_divide_factor, vco_range_select;
    logic [1:0] bresp, rresp;
    logic crystal_clock, vco_clock, oscillator_enable_in, stop_mode_in;
    logic base_clock_out, lock_change_irq, osc_run, pll_run, auto_bandwidth, tracking_select;
    logic s, moved;
    int fails, n_tests;

    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    pll_clock_selector dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock), .pll_lock_in(pll_lock_in),
        .pll_track_in(pll_track_in), .oscillator_enable_in(oscillator_enable_in),
        .stop_mode_in(stop_mode_in), .base_clock_out(base_clock_out),
        .lock_change_irq(lock_change_irq), .osc_run(osc_run), .pll_run(pll_run),
        .feedback_divide_factor(feedback_divide_factor), .vco_range_select(vco_range_select),
        .auto_bandwidth(auto_bandwidth), .tracking_select(tracking_select)
    );

    sim_side_model side (
        .aclk(aclk), .osc_run(osc_run), .pll_run(pll_run), .en_req(en_req),
        .stop_req(stop_req), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .oscillator_enable_in(oscillator_enable_in), .stop_mode_in(stop_mode_in)
    );

    // Value comparison, counted
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // Time comparison; two aclk periods of slack for the input synchronisers
    task automatic chk_near(input string what, input realtime e, input realtime g);
        n_tests++;
        if (g < e - 8.0 || g > e + 8.0) begin
            fails++;
            $display("CHECK FAILED %s expected %0.1f seen %0.1f", what, e, g);
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        chk("bvalid", 1, bvalid);
        chk("bresp", er, bresp);
    endtask

    // Read; mask hides bits whose value does not matter to the caller
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY,
                      input logic [7:0] m = 8'hff);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        chk("rvalid", 1, rvalid);
        chk("rresp", er, rresp);
        chk("rdata", {24'h0, e & m}, {rdata[31:8], rdata[7:0] & m});
    endtask

    // Four base clock periods, edge to edge
    task automatic period(input realtime e);
        realtime t0;
        @(posedge base_clock_out);
        t0 = $realtime;
        repeat (4) @(posedge base_clock_out);
        chk_near("base period x4", e, $realtime - t0);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end

    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h1;
        pll_lock_in = 1'b0;
        pll_track_in = 1'b0;
        en_req = 1'b1;
        stop_req = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state of the three registers
        rd(CTRL_ADDR, 8'h2f);
        rd(BAND_ADDR, 8'h00);
        rd(PROG_ADDR, 8'h66);
        chk("n out", 4'h6, feedback_divide_factor);
        period(640.0);
        wr(PROG_ADDR, 8'h12);
        rd(PROG_ADDR, 8'h66);
        wr(CTRL_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h0f);
        // N and L stand for software's rounded frequency ratios
        // L picked as the range nearest the VCO frequency
        wr(PROG_ADDR, 8'h05);
        rd(PROG_ADDR, 8'h05);
        chk("n zero", 4'h1, feedback_divide_factor);
        chk("range", 4'h5, vco_range_select);
        // Power on and select in one write: only power takes effect
        wr(CTRL_ADDR, 8'h30);
        rd(CTRL_ADDR, 8'h2f);
        chk("pll run", 1, pll_run);
        wr(CTRL_ADDR, 8'h30);
        #1;
        s = base_clock_out;
        moved = 1'b0;
        repeat (35) @(posedge aclk) moved |= (base_clock_out !== s);
        chk("base frozen", 0, moved);
        rd(CTRL_ADDR, 8'h3f);
        repeat (150) @(posedge aclk);
        period(384.0);
        wr(CTRL_ADDR, 8'h10);
        rd(CTRL_ADDR, 8'h3f);
        // Stop entry drops the selection and returns to the crystal
        stop_req <= 1'b1;
        repeat (3) @(posedge aclk);
        stop_req <= 1'b0;
        rd(CTRL_ADDR, 8'h2f);
        repeat (150) @(posedge aclk);
        period(640.0);
        // Manual bandwidth: enable held at zero, flag and lock bits read as zero
        wr(CTRL_ADDR, 8'ha0);
        rd(CTRL_ADDR, 8'h2f);
        pll_lock_in <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(BAND_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h2f);
        chk("irq manual", 0, lock_change_irq);
        // Automatic bandwidth: lock change raises the interrupt
        wr(BAND_ADDR, 8'h80);
        rd(CTRL_ADDR, 8'h00, RESP_OKAY, 8'h00);
        rd(BAND_ADDR, 8'hc0);
        chk("auto", 1, auto_bandwidth);
        wr(CTRL_ADDR, 8'ha0);
        rd(CTRL_ADDR, 8'haf);
        pll_lock_in <= 1'b0;
        repeat (10) @(posedge aclk);
        chk("irq set", 1, lock_change_irq);
        rd(CTRL_ADDR, 8'hef);
        repeat (3) @(posedge aclk);
        chk("irq clear", 0, lock_change_irq);
        rd(CTRL_ADDR, 8'haf);
        wr(BAND_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h2f);
        // Enable from the integration side gates both runs
        en_req <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("osc run off", 0, osc_run);
        chk("pll run off", 0, pll_run);
        en_req <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("pll run back", 1, pll_run);
        // Range zero keeps the PLL down and refuses selection
        wr(CTRL_ADDR, 8'h00);
        wr(PROG_ADDR, 8'h60);
        wr(CTRL_ADDR, 8'h20);
        chk("pll run L0", 0, pll_run);
        wr(CTRL_ADDR, 8'h30);
        rd(CTRL_ADDR, 8'h2f);
        // Unmapped offset answers with an error
        wr(8'h0c, 8'h55, RESP_SLVERR);
        rd(8'h0c, 8'h00, RESP_SLVERR);
        tally_and_finish();
    end
endmodule
`default_nettype wire
